/* hrcs_defines.svh */
// constants for the hub reset and configuration sequencer
`ifndef HRCS_DEFINES_SVH
`define HRCS_DEFINES_SVH
`define HRCS_CLK_MHZ 20
`define HRCS_RECOVERY_US 500
`define HRCS_RECOVERY_CYC ((`HRCS_RECOVERY_US * `HRCS_CLK_MHZ) - 1)
`define HRCS_LOAD_BP_US 99500
`define HRCS_LOAD_BP_CYC (`HRCS_LOAD_BP_US * `HRCS_CLK_MHZ)
`define HRCS_ATTACH_US 100000
`define HRCS_ATTACH_CYC (`HRCS_ATTACH_US * `HRCS_CLK_MHZ)
`define HRCS_APPLY_CYC 16
`define HRCS_REQ_US 5000
`define HRCS_REQ_CYC (`HRCS_REQ_US * `HRCS_CLK_MHZ)
`define HRCS_CNT_W 22
`define HRCS_PORT_PWR_RST 7'h00
`define HRCS_CFG_RST 8'h00
`define HRCS_ADDR_RST 7'h00
`endif

/* hrcs_host_model.sv */
// upstream host and smbus configuration host model for the sequencer bench
`timescale 1ns/1ps
module hrcs_host_model
#(
	parameter int LOAD_CYC = 40,
	parameter int GAP_CYC = 60,
	parameter int RST_CYC = 12
)
(
	// clock
	input wire logic mclk,
	// from the hub; kick comes from the bench
	input wire logic cfg_window,
	input wire logic attach,
	input wire logic kick,
	// to the hub
	output logic cfg_load_done,
	output logic usb_bus_reset
);
	int load_cnt = 0;
	int gap_cnt = 0;
	int rst_cnt = 0;
	logic fired = 1'b0;
	initial
	begin
		cfg_load_done = 1'b0;
		usb_bus_reset = 1'b0;
	end
	// host finishes well inside the bus-powered limit; done drops once the window closes
	always @(posedge mclk)
		if (!cfg_window)
		begin
			load_cnt <= 0;
			cfg_load_done <= 1'b0;
		end
		else if (load_cnt < LOAD_CYC)
			load_cnt <= load_cnt + 1;
		else
			cfg_load_done <= 1'b1;
	// gap is far shorter than the real host wait, to keep the run short
	always @(posedge mclk)
	begin
		if (attach && !fired)
			gap_cnt <= GAP_CYC;
		else if (gap_cnt > 0)
			gap_cnt <= gap_cnt - 1;
		if (attach)
			fired <= 1'b1;
		if (kick || gap_cnt == 1)
			rst_cnt <= RST_CYC;
		else if (rst_cnt > 0)
			rst_cnt <= rst_cnt - 1;
		usb_bus_reset <= (rst_cnt > 1);
	end
endmodule

/* hrcs_pkg.sv */
// types for the hub reset and configuration sequencer
package hrcs_pkg;
	typedef enum logic [2:0]
	{
		HRCS_RECOVER = 3'h0,
		HRCS_LOAD = 3'h1,
		HRCS_APPLY = 3'h2,
		HRCS_ATTACHED = 3'h3,
		HRCS_BUSRST = 3'h4,
		HRCS_RUN = 3'h5
	} hrcs_state_t;
endpackage

/* hrcs_timer.sv */
// down-counting timer with one-shot expiry level
`timescale 1ns/1ps
module hrcs_timer
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// control
	hrcs_tmr_if.tmr t
);
	logic [21:0] cnt_r;
	logic run_r;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cnt_r <= 22'h000000;
			run_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (t.start)
			begin
				cnt_r <= t.limit;
				run_r <= 1'b1;
			end
			else if (run_r && cnt_r != 22'h000000)
				cnt_r <= cnt_r - 22'h000001;
		end
	end
	// expiry reads registers only, so the sequencer may restart the timer from it
	assign t.expired = run_r && cnt_r == 22'h000000;
endmodule

/* hrcs_tmr_if.sv */
// load and start signals between the sequencer and its timer
`timescale 1ns/1ps
interface hrcs_tmr_if;
	logic start;
	logic [21:0] limit;
	logic expired;
	modport ctl (output start, output limit, input expired);
	modport tmr (input start, input limit, output expired);
endinterface

/* hrcs_top.sv */
// hub sequencer from hardware reset through smbus load, attach and bus reset
`timescale 1ns/1ps
`include "hrcs_defines.svh"
module hrcs_top
(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// pins from outside
	input wire logic self_powered,
	input wire logic cfg_load_done,
	input wire logic usb_bus_reset,
	input wire logic usb_suspend,
	// from hub core, same clock
	input wire logic req_start,
	input wire logic req_done,
	input wire logic [6:0] set_addr,
	input wire logic set_addr_stb,
	input wire logic [7:0] set_cfg,
	input wire logic set_cfg_stb,
	input wire logic [7:1] port_power_req,
	// outputs
	output logic operational_r,
	output logic cfg_window_r,
	output logic cfg_applied_r,
	output logic usb_attach_r,
	output logic [6:0] dev_addr_r,
	output logic [7:0] dev_cfg_r,
	output logic [7:1] port_power_enable_r,
	output logic tt_flush_r,
	output logic suspended_r,
	output logic ds_reset_r,
	output logic load_timeout_r,
	output logic req_timeout_r
);
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic [3:0] s3_r;
	logic sp_s;
	logic done_s;
	logic brst_s;
	logic susp_s;
	logic brst_rise;
	hrcs_pkg::hrcs_state_t st_r;
	hrcs_pkg::hrcs_state_t st_nxt;
	hrcs_tmr_if tif();
	logic [21:0] req_cnt_r;
	logic req_busy_r;
	logic rec_arm_r;

	// two-flop synchronisers; third stage only for edge detection
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
		end
		else if (clk_en)
		begin
			s1_r <= {usb_suspend, usb_bus_reset, cfg_load_done, self_powered};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign sp_s = s2_r[0];
	assign done_s = s2_r[1];
	assign brst_s = s2_r[2];
	assign susp_s = s2_r[3];
	assign brst_rise = s2_r[2] && !s3_r[2];

	hrcs_timer u_tmr
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.t(tif.tmr)
	);

	always_comb
	begin
		st_nxt = st_r;
		tif.start = 1'b0;
		tif.limit = 22'h000000;
		unique case (st_r)
			hrcs_pkg::HRCS_RECOVER:
				if (rec_arm_r)
				begin
					tif.start = 1'b1;
					tif.limit = 22'(`HRCS_RECOVERY_CYC);
				end
				else if (tif.expired)
				begin
					st_nxt = hrcs_pkg::HRCS_LOAD;
					tif.start = 1'b1;
					tif.limit = 22'(`HRCS_LOAD_BP_CYC);
				end
			hrcs_pkg::HRCS_LOAD:
				// self-powered ignores the timer; bus-powered ends on it
				if (done_s || (!sp_s && tif.expired))
				begin
					st_nxt = hrcs_pkg::HRCS_APPLY;
					tif.start = 1'b1;
					tif.limit = 22'(`HRCS_APPLY_CYC);
				end
			hrcs_pkg::HRCS_APPLY:
				if (tif.expired)
					st_nxt = hrcs_pkg::HRCS_ATTACHED;
			hrcs_pkg::HRCS_ATTACHED:
				if (brst_rise)
					st_nxt = hrcs_pkg::HRCS_BUSRST;
			hrcs_pkg::HRCS_BUSRST:
				if (!brst_s)
					st_nxt = hrcs_pkg::HRCS_RUN;
			hrcs_pkg::HRCS_RUN:
				if (brst_rise)
					st_nxt = hrcs_pkg::HRCS_BUSRST;
			default:
				st_nxt = hrcs_pkg::HRCS_RECOVER;
		endcase
	end

	// recovery timer is armed by the reset itself
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			st_r <= hrcs_pkg::HRCS_RECOVER;
		else if (clk_en)
			st_r <= st_nxt;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			rec_arm_r <= 1'b1;
		else if (clk_en)
			rec_arm_r <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			operational_r <= 1'b0;
			cfg_window_r <= 1'b0;
			cfg_applied_r <= 1'b0;
			usb_attach_r <= 1'b0;
			load_timeout_r <= 1'b0;
		end
		else if (clk_en)
		begin
			operational_r <= st_nxt != hrcs_pkg::HRCS_RECOVER;
			cfg_window_r <= st_nxt == hrcs_pkg::HRCS_LOAD;
			cfg_applied_r <= st_nxt == hrcs_pkg::HRCS_ATTACHED ||
				st_nxt == hrcs_pkg::HRCS_BUSRST || st_nxt == hrcs_pkg::HRCS_RUN;
			usb_attach_r <= st_nxt == hrcs_pkg::HRCS_ATTACHED ||
				st_nxt == hrcs_pkg::HRCS_BUSRST || st_nxt == hrcs_pkg::HRCS_RUN;
			if (st_r == hrcs_pkg::HRCS_LOAD && !done_s && !sp_s && tif.expired)
				load_timeout_r <= 1'b1;
		end
	end

	// bus reset actions
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			dev_addr_r <= `HRCS_ADDR_RST;
			dev_cfg_r <= `HRCS_CFG_RST;
			port_power_enable_r <= `HRCS_PORT_PWR_RST;
			tt_flush_r <= 1'b0;
			suspended_r <= 1'b0;
			ds_reset_r <= 1'b0;
		end
		else if (clk_en)
		begin
			ds_reset_r <= 1'b0;
			tt_flush_r <= st_nxt == hrcs_pkg::HRCS_BUSRST;
			if (st_nxt == hrcs_pkg::HRCS_BUSRST)
			begin
				dev_addr_r <= `HRCS_ADDR_RST;
				dev_cfg_r <= 8'h00;
				port_power_enable_r <= 7'h00;
				suspended_r <= 1'b0;
			end
			else if (st_r == hrcs_pkg::HRCS_RUN)
			begin
				if (set_addr_stb)
					dev_addr_r <= set_addr;
				if (set_cfg_stb)
					dev_cfg_r <= set_cfg;
				port_power_enable_r <= (dev_cfg_r != 8'h00) ? port_power_req : 7'h00;
				suspended_r <= susp_s;
			end
		end
	end

	// request watchdog: flags a request held past its completion budget
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			req_cnt_r <= 22'h000000;
			req_busy_r <= 1'b0;
			req_timeout_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (st_r != hrcs_pkg::HRCS_RUN || req_done)
			begin
				req_busy_r <= 1'b0;
				req_cnt_r <= 22'h000000;
			end
			else if (req_start)
			begin
				req_busy_r <= 1'b1;
				req_cnt_r <= 22'h000000;
			end
			else if (req_busy_r)
			begin
				req_cnt_r <= req_cnt_r + 22'h000001;
				if (req_cnt_r == 22'(`HRCS_REQ_CYC - 1))
					req_timeout_r <= 1'b1;
			end
		end
	end

	// the apply phase runs a fixed count of enabled cycles
	sequence s_apply_run;
		clk_en [*8] ##1 clk_en [*8];
	endsequence

	a_attach_after_load: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(usb_attach_r) |-> $past(st_r) == hrcs_pkg::HRCS_APPLY && !cfg_window_r)
		else $error("attach raised outside the apply phase");
	a_addr_zero_rst: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && st_nxt == hrcs_pkg::HRCS_BUSRST) |=> dev_addr_r == 7'h00)
		else $error("address not cleared on bus reset");
	a_cfg_zero_rst: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && st_nxt == hrcs_pkg::HRCS_BUSRST) |=> dev_cfg_r == 8'h00)
		else $error("configuration kept over bus reset");
	a_power_off_rst: assert property (@(posedge mclk) disable iff (sys_rst)
		(st_r == hrcs_pkg::HRCS_BUSRST) |-> port_power_enable_r == 7'h00)
		else $error("port power on during bus reset");
	a_tt_flush: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && st_nxt == hrcs_pkg::HRCS_BUSRST) |=> tt_flush_r)
		else $error("translator flush missing");
	a_wake_on_rst: assert property (@(posedge mclk) disable iff (sys_rst)
		(st_r == hrcs_pkg::HRCS_BUSRST) |-> !suspended_r)
		else $error("still suspended during bus reset");
	a_no_fwd_rst: assert property (@(posedge mclk) disable iff (sys_rst)
		!ds_reset_r)
		else $error("bus reset forwarded downstream");
	a_attach_time: assert property (@(posedge mclk) disable iff (sys_rst)
		(clk_en && st_r == hrcs_pkg::HRCS_LOAD && st_nxt == hrcs_pkg::HRCS_APPLY)
		##1 s_apply_run |-> ##[1:4] usb_attach_r)
		else $error("attach late after load");
	a_load_window: assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_window_r |-> operational_r && !usb_attach_r)
		else $error("load window while not operational");
endmodule

/* hub_reset_config_sequencer_test.sv */
// self-checking bench for the hub reset and configuration sequencer
`timescale 1ns/1ps
`include "hrcs_defines.svh"
module hub_reset_config_sequencer_test;
	logic mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, self_powered = 1'b1, usb_suspend = 1'b0;
	logic req_start = 1'b0, req_done = 1'b0, set_addr_stb = 1'b0, set_cfg_stb = 1'b0, kick = 1'b0;
	logic [6:0] set_addr = 7'h00;
	logic [7:0] set_cfg = 8'h00;
	logic [7:1] port_power_req = 7'h00;
	logic cfg_load_done, usb_bus_reset, operational_r, cfg_window_r, cfg_applied_r, usb_attach_r;
	logic tt_flush_r, suspended_r, ds_reset_r, load_timeout_r, req_timeout_r;
	logic [6:0] dev_addr_r;
	logic [7:0] dev_cfg_r;
	logic [7:1] port_power_enable_r;
	int n_mismatch = 0, n_compared = 0;
	// address, config, power request, expected power enable
	logic [28:0] rows [3] = '{{7'h05, 8'h01, 7'h7F, 7'h7F}, {7'h7F, 8'h00, 7'h55, 7'h00},
		{7'h2C, 8'h02, 7'h2A, 7'h2A}};
	hrcs_top dut_u (.mclk, .sys_rst, .clk_en, .self_powered, .cfg_load_done, .usb_bus_reset,
		.usb_suspend, .req_start, .req_done, .set_addr, .set_addr_stb, .set_cfg, .set_cfg_stb,
		.port_power_req, .operational_r, .cfg_window_r, .cfg_applied_r, .usb_attach_r,
		.dev_addr_r, .dev_cfg_r, .port_power_enable_r, .tt_flush_r, .suspended_r,
		.ds_reset_r, .load_timeout_r, .req_timeout_r);
	hrcs_host_model host_u (.mclk, .cfg_window(cfg_window_r), .attach(usb_attach_r), .kick,
		.cfg_load_done, .usb_bus_reset);
	initial
		forever #25 mclk = ~mclk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// bounded wait on window, attach or flush; a miss ends the run
	task automatic wait_for(input int sel, input int lim);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < lim && !hit; i++)
		begin
			@(negedge mclk);
			hit = sel == 0 ? cfg_window_r === 1'b1 : sel == 1 ? usb_attach_r === 1'b1 :
				tt_flush_r === 1'b1;
		end
		if (!hit)
		begin
			chk(8'h00, 8'h01);
			print_verdict();
		end
	endtask
	always @(negedge mclk)
		if (!sys_rst)
		begin
			chk({7'h00, ds_reset_r}, 8'h00);
			chk({7'h00, usb_attach_r & cfg_window_r}, 8'h00);
		end
	initial
	begin
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		chk({7'h00, usb_attach_r}, 8'h00);
		repeat (`HRCS_RECOVERY_CYC - 2) @(negedge mclk);
		chk({7'h00, operational_r}, 8'h00);
		wait_for(0, 6);
		chk({7'h00, operational_r}, 8'h01);
		wait_for(1, 40 + `HRCS_APPLY_CYC + 12);
		chk({7'h00, cfg_applied_r}, 8'h01);
		wait_for(2, 100);
		repeat (2) @(negedge mclk);
		chk({1'b0, dev_addr_r}, 8'h00);
		chk(dev_cfg_r, 8'h00);
		chk({1'b0, port_power_enable_r}, 8'h00);
		repeat (20) @(negedge mclk);
		foreach (rows[i])
		begin
			{set_addr, set_cfg, port_power_req} = rows[i][28:7];
			set_addr_stb = 1'b1;
			set_cfg_stb = 1'b1;
			@(negedge mclk);
			set_addr_stb = 1'b0;
			set_cfg_stb = 1'b0;
			repeat (3) @(negedge mclk);
			chk({1'b0, dev_addr_r}, {1'b0, rows[i][28:22]});
			chk(dev_cfg_r, rows[i][21:14]);
			chk({1'b0, port_power_enable_r}, {1'b0, rows[i][6:0]});
		end
		req_start = 1'b1;
		@(negedge mclk);
		req_start = 1'b0;
		repeat (10) @(negedge mclk);
		req_done = 1'b1;
		@(negedge mclk);
		req_done = 1'b0;
		chk({7'h00, req_timeout_r}, 8'h00);
		// suspended, configured and powered when the second bus reset lands
		usb_suspend = 1'b1;
		repeat (5) @(negedge mclk);
		chk({7'h00, suspended_r}, 8'h01);
		kick = 1'b1;
		@(negedge mclk);
		kick = 1'b0;
		wait_for(2, 20);
		@(negedge mclk);
		chk({7'h00, suspended_r}, 8'h00);
		usb_suspend = 1'b0;
		chk({1'b0, dev_addr_r}, 8'h00);
		chk(dev_cfg_r, 8'h00);
		chk({1'b0, port_power_enable_r}, 8'h00);
		chk({7'h00, load_timeout_r}, 8'h00);
		// mid-run reset into bus-powered mode; the host loads well inside the limit
		self_powered = 1'b0;
		sys_rst = 1'b1;
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		chk({7'h00, usb_attach_r}, 8'h00);
		wait_for(0, `HRCS_RECOVERY_CYC + 8);
		wait_for(1, 40 + `HRCS_APPLY_CYC + 12);
		chk({7'h00, load_timeout_r}, 8'h00);
		chk({7'h00, cfg_applied_r}, 8'h01);
		print_verdict();
	end
endmodule
